// ---- prio_bank.sv ----
// APB bank of six priority registers for twenty interrupt sources
//
// Function
// [R01] Three-bit field; all-ones code means level 7, the highest.
// [R02] Code 001 means level 1, the lowest enabled level.
// [R03] Code 000 disables the source; it never raises a request.
// [R04] Unimplemented bits always read as zero.
// [R05] Every field resets to code 100, level 4.
// [R06] Every field is writable and reads back the last value written.
// [R07] First register: only bits 2-0, external interrupt 1.
// [R08] Second: timer 4, compare 4, compare 3, DMA 2.
// [R09] Third: UART2 transmit, UART2 receive, external interrupt 2, timer 5.
// [R10] Fourth: crypto rollover, crypto buffer free, SPI2 transmit, SPI2 general.
// [R11] Fifth: capture 5, capture 4, capture 3, DMA 3.
// [R12] Sixth: bits 15-11 zero; compare 6, compare 5, capture 6.
// [R13] Bits 15, 11, 7 and 3 of registers two to five read zero.
// [R14] Codes map linearly to levels; levels go out to the arbiter.
// [R15] Writes to unimplemented bits are dropped and store nothing.
module prio_bank
  import prio_bank_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [AW-1:0]       paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  input  wire logic [3:0]          pstrb,
  input  wire logic [NUM_SRCS-1:0] src_irq,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  output src_levels_t              levels,
  output logic      [NUM_SRCS-1:0] src_enable,
  output logic      [NUM_SRCS-1:0] irq_req
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic [DATA_W-1:0]   prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;
  logic [NUM_SRCS-1:0] irq_req_reg;
  logic [NUM_SRCS-1:0] enabled;
  logic [2:0]          lvl [NUM_SRCS];
  logic [REG_W-1:0]    rd_word;

  wire       setup_phase = psel && !penable;
  wire       access_done = psel && penable && pready_reg;
  wire [2:0] reg_idx     = paddr[4:2];
  // Upper address bits and misaligned byte address both miss the map
  wire       upper_zero  = (paddr[AW-1:5] == '0);
  wire       aligned     = (paddr[1:0] == 2'b00);
  wire       mapped      = upper_zero && aligned && (reg_idx < 3'(NUM_REGS));
  wire       wr_commit   = access_done && pwrite && mapped;

  // ==========================================================================
  // Priority fields
  // ==========================================================================
  // [R06] Fields read back
  // [R07] First register field
  // [R08] Second register fields
  // [R09] Third register fields
  // [R10] Fourth register fields
  // [R11] Fifth register fields
  // [R12] Sixth register fields
  // [R13] Separators left unstored
  // Each field sees only its own three bits and its byte lane, so a write
  // to separator or unused bits has nowhere to land.
  genvar g;
  generate
    for (g = 0; g < NUM_SRCS; g++) begin : g_field
      wire       lane_on = pstrb[FIELD_LSB[g] / 8];
      wire       hit     = wr_commit && (reg_idx == 3'(FIELD_REG[g])) && lane_on;
      // [R15] Masked write path
      prio_field u_field (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (hit),
        .wr_data (pwdata[FIELD_LSB[g] +: LVL_W]),
        .level   (lvl[g]),
        .enabled (enabled[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Read data
  // ==========================================================================
  // [R04] Zero outside fields
  always_comb begin
    rd_word = '0;
    for (int i = 0; i < NUM_SRCS; i++) begin
      if (reg_idx == 3'(FIELD_REG[i])) begin
        rd_word = rd_word | (REG_W'(lvl[i]) << FIELD_LSB[i]);
      end
    end
  end

  // ==========================================================================
  // APB response
  // ==========================================================================
  // [R04] Upper half driven zero
  // Zero wait states: data captured in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase && !mapped;
      if (setup_phase) begin
        prdata_reg <= (!pwrite && mapped) ? {16'h0000, rd_word} : '0;
      end
    end
  end

  // ==========================================================================
  // Request gating toward the arbiter
  // ==========================================================================
  // [R03] Disabled sources gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_reg <= '0;
    end else begin
      irq_req_reg <= src_irq & enabled;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign irq_req    = irq_req_reg;
  assign src_enable = enabled;

  // [R14] Levels to the arbiter, codes passed unchanged
  assign levels.ext_int_one_level        = lvl[0];
  assign levels.dma_two_level            = lvl[1];
  assign levels.compare_three_level      = lvl[2];
  assign levels.compare_four_level       = lvl[3];
  assign levels.timer_four_level         = lvl[4];
  assign levels.timer_five_level         = lvl[5];
  assign levels.ext_int_two_level        = lvl[6];
  assign levels.uart_two_rx_level        = lvl[7];
  assign levels.uart_two_tx_level        = lvl[8];
  assign levels.spi_two_general_level    = lvl[9];
  assign levels.spi_two_tx_level         = lvl[10];
  assign levels.crypto_buffer_free_level = lvl[11];
  assign levels.crypto_rollover_level    = lvl[12];
  assign levels.dma_three_level          = lvl[13];
  assign levels.capture_three_level      = lvl[14];
  assign levels.capture_four_level       = lvl[15];
  assign levels.capture_five_level       = lvl[16];
  assign levels.capture_six_level        = lvl[17];
  assign levels.compare_five_level       = lvl[18];
  assign levels.compare_six_level        = lvl[19];

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Helper: high from reset until the first committed write
  logic fresh_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fresh_reg <= 1'b1;
    end else if (wr_commit) begin
      fresh_reg <= 1'b0;
    end
  end

  // Qualifiers shared by the checks below
  wire rd_done = access_done && !pwrite && mapped;
  wire full_lane_wr = wr_commit && (pstrb == 4'hF);

  // [R05] Reset level four
  a_reset_level_four: assert property (@(posedge pclk) disable iff (!presetn)
    fresh_reg |-> (levels == {NUM_SRCS{FIELD_RESET}}) && (&src_enable)) // [R05]
    else $error("field left its reset code before any write");

  // [R01] Top code enables
  a_top_code_seven: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd0 && pwdata[2:0] == LEVEL_TOP)
    |=> (levels.ext_int_one_level == LEVEL_TOP) && src_enable[0]) // [R01]
    else $error("code 7 not stored as an enabled level");

  // [R02] Lowest code enables
  a_low_code_one: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd5 && pwdata[10:8] == LEVEL_LOWEST)
    |=> (levels.compare_six_level == LEVEL_LOWEST) && src_enable[19]) // [R02]
    else $error("code 1 not stored as an enabled level");

  // [R03] Disabled never requests
  a_zero_no_request: assert property (@(posedge pclk) disable iff (!presetn)
    (!src_enable[5]) ##1 (!src_enable[5]) |-> !irq_req[5]) // [R03]
    else $error("disabled source raised a request");

  // [R14] Enabled source passes
  a_enabled_passes: assert property (@(posedge pclk) disable iff (!presetn)
    (src_irq[12] && src_enable[12]) |=> irq_req[12]) // [R14]
    else $error("enabled source request dropped");

  // [R06] Write then read back
  a_write_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd2)
    |=> (levels.uart_two_tx_level == $past(pwdata[14:12]))
     && (levels.timer_five_level == $past(pwdata[2:0]))) // [R06]
    else $error("stored level differs from written value");

  // [R15] Unused bits store nothing
  a_unused_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd0) |=> $stable(levels[59:3])) // [R15]
    else $error("write to first register touched another field");

  // [R07] First register read
  a_read_first_reg: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && reg_idx == 3'd0)
    |-> prdata == {29'h0000_0000, levels.ext_int_one_level}) // [R07]
    else $error("first register read wrong");

  // [R08] Second register read
  a_read_second_reg: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && reg_idx == 3'd1)
    |-> prdata == {17'h0_0000, levels.timer_four_level, 1'b0, levels.compare_four_level,
                   1'b0, levels.compare_three_level, 1'b0, levels.dma_two_level}) // [R08]
    else $error("second register read wrong");

  // [R09] Third register read
  a_read_third_reg: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && reg_idx == 3'd2)
    |-> prdata == {17'h0_0000, levels.uart_two_tx_level, 1'b0, levels.uart_two_rx_level,
                   1'b0, levels.ext_int_two_level, 1'b0, levels.timer_five_level}) // [R09]
    else $error("third register read wrong");

  // [R10] Fourth register read
  a_read_fourth_reg: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && reg_idx == 3'd3)
    |-> prdata == {17'h0_0000, levels.crypto_rollover_level, 1'b0,
                   levels.crypto_buffer_free_level, 1'b0, levels.spi_two_tx_level,
                   1'b0, levels.spi_two_general_level}) // [R10]
    else $error("fourth register read wrong");

  // [R11] Fifth register read
  a_read_fifth_reg: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && reg_idx == 3'd4)
    |-> prdata == {17'h0_0000, levels.capture_five_level, 1'b0, levels.capture_four_level,
                   1'b0, levels.capture_three_level, 1'b0, levels.dma_three_level}) // [R11]
    else $error("fifth register read wrong");

  // [R12] Sixth register read
  a_read_sixth_reg: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && reg_idx == 3'd5)
    |-> prdata == {21'h00_0000, levels.compare_six_level, 1'b0,
                   levels.compare_five_level, 1'b0, levels.capture_six_level}) // [R12]
    else $error("sixth register read wrong");

  // [R13] Separator bits zero
  a_separator_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done |-> (prdata[15] | prdata[11] | prdata[7] | prdata[3]) == 1'b0) // [R13]
    else $error("separator bit read as one");

  // [R04] Upper half zero
  a_upper_half_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access_done |-> prdata[31:16] == 16'h0000) // [R04]
    else $error("upper half of read data not zero");

  // [R01] Top code, fourth register
  a_top_code_crypto: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd3 && pwdata[14:12] == LEVEL_TOP)
    |=> (levels.crypto_rollover_level == LEVEL_TOP) && src_enable[12]) // [R01]
    else $error("code 7 not stored in fourth register");

  // [R02] Low code, fourth register
  a_low_code_spi: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd3 && pwdata[2:0] == LEVEL_LOWEST)
    |=> (levels.spi_two_general_level == LEVEL_LOWEST) && src_enable[9]) // [R02]
    else $error("code 1 not stored in fourth register");

  // [R03] Enable flag tracks code
  a_enable_tracks_code: assert property (@(posedge pclk) disable iff (!presetn)
    ((levels.timer_five_level != LEVEL_OFF) == src_enable[5])
    && ((levels.uart_two_tx_level != LEVEL_OFF) == src_enable[8])) // [R03]
    else $error("enable flag disagrees with stored code");

  // [R05] Reset word, second register
  a_reset_word_second: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && fresh_reg && reg_idx == 3'd1)
    |-> prdata == {17'h0_0000, FIELD_RESET, 1'b0, FIELD_RESET,
                   1'b0, FIELD_RESET, 1'b0, FIELD_RESET}) // [R05]
    else $error("second register read wrong after reset");

  // [R05] Reset word, sixth register
  a_reset_word_sixth: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && fresh_reg && reg_idx == 3'd5)
    |-> prdata == {21'h00_0000, FIELD_RESET, 1'b0, FIELD_RESET, 1'b0, FIELD_RESET}) // [R05]
    else $error("sixth register read wrong after reset");

  // [R06] Write then read back, fifth register
  a_write_readback_fifth: assert property (@(posedge pclk) disable iff (!presetn)
    (full_lane_wr && reg_idx == 3'd4)
    |=> (levels.capture_five_level == $past(pwdata[14:12]))
     && (levels.dma_three_level == $past(pwdata[2:0]))) // [R06]
    else $error("fifth register level differs from written value");

  // [R04] Unmapped read is zero
  a_unmapped_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && !mapped) |-> prdata == 32'h0000_0000) // [R04]
    else $error("unmapped access returned data");

  // [R15] Unmapped write stores nothing
  a_unmapped_no_store: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && !mapped) |=> $stable(levels)) // [R15]
    else $error("unmapped write changed a level");

  // [R15] Strobed-off lane kept
  a_lane_off_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_commit && reg_idx == 3'd1 && pstrb == 4'h1)
    |=> $stable({levels.timer_four_level, levels.compare_four_level})) // [R15]
    else $error("write touched a lane with its strobe low");

  // Error answer only on unmapped places
  a_error_on_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    access_done |-> (pslverr == !mapped))
    else $error("error response disagrees with address map");

  // Error rides with ready
  a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");

  // Ready lasts one cycle
  a_ready_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  // Bus answers in the first access cycle
  a_ready_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready ##1 !pready || setup_phase)
    else $error("ready not given in first access cycle");

endmodule // prio_bank

// ---- prio_bank_pkg.sv ----
// Package holding the map, field layout and reset code of the priority bank
package prio_bank_pkg;

  // ==========================================================================
  // Bus and map geometry
  // ==========================================================================
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned LVL_W      = 3;
  localparam int unsigned NUM_REGS   = 6;
  localparam int unsigned NUM_SRCS   = 20;

  // Byte offsets of the six registers
  localparam logic [11:0] EXT_INT_ONE_PRIORITY_OFFS          = 12'h0000;
  localparam logic [11:0] TIMER4_COMPARE_DMA2_PRIORITY_OFFS  = 12'h0004;
  localparam logic [11:0] UART2_EXTINT2_TIMER5_PRIORITY_OFFS = 12'h0008;
  localparam logic [11:0] CRYPTO_SPI2_PRIORITY_OFFS          = 12'h000C;
  localparam logic [11:0] CAPTURE_DMA3_PRIORITY_OFFS         = 12'h0010;
  localparam logic [11:0] COMPARE_CAPTURE_SIX_PRIORITY_OFFS  = 12'h0014;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int unsigned SLOT_A_LSB = 0;
  localparam int unsigned SLOT_B_LSB = 4;
  localparam int unsigned SLOT_C_LSB = 8;
  localparam int unsigned SLOT_D_LSB = 12;

  // Implemented bits of each register; everything else reads as zero
  localparam logic [15:0] MASK_ONE_SLOT    = 16'h0007;
  localparam logic [15:0] MASK_FOUR_SLOTS  = 16'h7777;
  localparam logic [15:0] MASK_THREE_SLOTS = 16'h0777;

  // Reset code: top bit set, lower two clear, level 4
  localparam logic [2:0] FIELD_RESET  = 3'h4;
  localparam logic [2:0] LEVEL_OFF    = 3'h0;
  localparam logic [2:0] LEVEL_LOWEST = 3'h1;
  localparam logic [2:0] LEVEL_TOP    = 3'h7;

  // Register index and bit position of each source, in source order
  localparam int unsigned FIELD_REG [NUM_SRCS] = '{
    0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 5, 5, 5};
  localparam int unsigned FIELD_LSB [NUM_SRCS] = '{
    SLOT_A_LSB,
    SLOT_A_LSB, SLOT_B_LSB, SLOT_C_LSB, SLOT_D_LSB,
    SLOT_A_LSB, SLOT_B_LSB, SLOT_C_LSB, SLOT_D_LSB,
    SLOT_A_LSB, SLOT_B_LSB, SLOT_C_LSB, SLOT_D_LSB,
    SLOT_A_LSB, SLOT_B_LSB, SLOT_C_LSB, SLOT_D_LSB,
    SLOT_A_LSB, SLOT_B_LSB, SLOT_C_LSB};

  // ==========================================================================
  // Carrier: every source level presented to the arbiter
  // ==========================================================================
  typedef struct packed {
    logic [2:0] compare_six_level;
    logic [2:0] compare_five_level;
    logic [2:0] capture_six_level;
    logic [2:0] capture_five_level;
    logic [2:0] capture_four_level;
    logic [2:0] capture_three_level;
    logic [2:0] dma_three_level;
    logic [2:0] crypto_rollover_level;
    logic [2:0] crypto_buffer_free_level;
    logic [2:0] spi_two_tx_level;
    logic [2:0] spi_two_general_level;
    logic [2:0] uart_two_tx_level;
    logic [2:0] uart_two_rx_level;
    logic [2:0] ext_int_two_level;
    logic [2:0] timer_five_level;
    logic [2:0] timer_four_level;
    logic [2:0] compare_four_level;
    logic [2:0] compare_three_level;
    logic [2:0] dma_two_level;
    logic [2:0] ext_int_one_level;
  } src_levels_t;

endpackage

// ---- prio_field.sv ----
// One three-bit priority field with its enable flag
module prio_field
  import prio_bank_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_data,
  output logic      [2:0] level,
  output logic            enabled
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [2:0] level_reg;
  logic       enabled_reg;
  logic [2:0] level_next;

  // [R01] Code kept as level
  // Flag follows the stored code so both leave flops together
  assign level_next = wr_en ? wr_data : level_reg;

  // [R05] Reset code four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg   <= FIELD_RESET;
      enabled_reg <= 1'b1;
    end else begin
      level_reg   <= level_next;
      enabled_reg <= (level_next != LEVEL_OFF);
    end
  end

  assign level   = level_reg;
  assign enabled = enabled_reg;

endmodule // prio_field

// ---- testbench.sv ----
// Self-checking bench for the six-register priority bank
module testbench
  import prio_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and bookkeeping
  // ==========================================================================
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [31:0] rdata;
    logic        err;
  } row_t;

  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [3:0]          pstrb;
  logic [19:0]         src_irq;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  src_levels_t         levels;
  logic [19:0]         src_enable;
  logic [19:0]         irq_req;
  logic [15:0]         exp_reg [6];
  logic [19:0]         exp_en;
  logic [31:0]         rd;
  logic                er;
  int                  n_errors;
  int                  n_checks;
  int                  cycles;

  // Write each register, then read back; unmapped places last
  row_t rows [11] = '{
    '{12'h000, 32'hFFFF_FFFF, 4'hF, 32'h0000_0007, 1'b0},
    '{12'h004, 32'hFFFF_FFFF, 4'hF, 32'h0000_7777, 1'b0},
    '{12'h008, 32'h0000_8888, 4'hF, 32'h0000_0000, 1'b0},
    '{12'h00C, 32'h1234_7531, 4'hF, 32'h0000_7531, 1'b0},
    '{12'h010, 32'h0000_2461, 4'hF, 32'h0000_2461, 1'b0},
    '{12'h014, 32'hFFFF_F165, 4'hF, 32'h0000_0165, 1'b0},
    '{12'h004, 32'h0000_1357, 4'h1, 32'h0000_7757, 1'b0},
    '{12'h008, 32'hABCD_3610, 4'hF, 32'h0000_3610, 1'b0},
    '{12'h018, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1},
    '{12'h002, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1},
    '{12'h020, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1}};

  prio_bank dut (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .src_irq    (src_irq),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .levels     (levels),
    .src_enable (src_enable),
    .irq_req    (irq_req)
  );

  // ==========================================================================
  // Clock and hang guard
  // ==========================================================================
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Whole run needs under a hundred cycles; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      stop_test();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; psel stays up so a setup may follow at once
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rdv, output logic erv);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
  endtask

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Source i sits in register (i+3)/4, slot (i+3)%4; source 0 alone in slot 0
  task automatic check_levels();
    int r;
    int l;
    for (int i = 0; i < 20; i++) begin
      r = (i + 3) / 4;
      l = (i == 0) ? 0 : 4 * ((i + 3) % 4);
      exp_en[i] = (exp_reg[r][l +: 3] != 3'h0);
      check(32'(levels[3*i +: 3]), 32'(exp_reg[r][l +: 3]));
      check(32'(src_enable[i]), 32'(exp_en[i]));
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    pstrb    = 4'h0;
    src_irq  = 20'h0_0000;
    n_errors = 0;
    n_checks = 0;
    cycles   = 0;
    exp_reg  = '{16'h0004, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h0444};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset codes on every field and every read word
    check_levels();
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, 12'(4 * k), 32'h0000_0000, 4'h0, rd, er);
      check(rd, 32'(exp_reg[k]));
    end
    idle();
    // Table: write then read back to back, model updated on mapped rows
    for (int k = 0; k < 11; k++) begin
      xfer(1'b1, rows[k].addr, rows[k].wdata, rows[k].strb, rd, er);
      check(32'(er), 32'(rows[k].err));
      xfer(1'b0, rows[k].addr, 32'h0000_0000, 4'h0, rd, er);
      check(rd, rows[k].rdata);
      check(32'(er), 32'(rows[k].err));
      if (rows[k].err === 1'b0) begin
        exp_reg[rows[k].addr[4:2]] = rows[k].rdata[15:0];
      end
      idle();
    end
    check_levels();
    // Requests pass only for enabled sources, one cycle late
    src_irq <= 20'hF_FFFF;
    repeat (2) @(posedge pclk);
    check(32'(irq_req), 32'(exp_en));
    src_irq <= 20'hA_5A5A;
    repeat (2) @(posedge pclk);
    check(32'(irq_req), 32'(20'hA_5A5A & exp_en));
    // Reset in mid-run restores level 4 everywhere
    presetn <= 1'b0;
    exp_reg  = '{16'h0004, 16'h4444, 16'h4444, 16'h4444, 16'h4444, 16'h0444};
    @(posedge pclk);
    check_levels();
    check(32'(irq_req), 32'h0000_0000);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h014, 32'h0000_0000, 4'h0, rd, er);
    check(rd, 32'h0000_0444);
    idle();
    stop_test();
  end

endmodule // testbench
